// ### rtl/rcal_params.svh
`ifndef RCAL_PARAMS_SVH
`define RCAL_PARAMS_SVH
// Register byte offsets
`define RCAL_OFS_CFG 8'h00
`define RCAL_OFS_TRIM 8'h04
`define RCAL_OFS_PAD 8'h08
`define RCAL_OFS_ACFG 8'h0C
`define RCAL_OFS_RPT 8'h10
`define RCAL_OFS_TVH 8'h14
`define RCAL_OFS_TVL 8'h18
`define RCAL_OFS_AVH 8'h1C
`define RCAL_OFS_AVL 8'h20
`define RCAL_OFS_KEY 8'h24
// Field positions
`define RCAL_CFG_EN 7
`define RCAL_CFG_UNLOCK 5
`define RCAL_CFG_SYNC 4
`define RCAL_CFG_HALF 3
`define RCAL_CFG_OE 2
`define RCAL_ACFG_EN 7
`define RCAL_ACFG_ENDLESS 6
// Values
`define RCAL_KEY_FIRST 8'h55
`define RCAL_KEY_SECOND 8'hAA
`define RCAL_RPT_RESET 8'h00
`define RCAL_RPT_WRAP 8'hFF
`define RCAL_SEL_ALARM 2'b00
`define RCAL_SEL_SECONDS 2'b01
// Timing
`define RCAL_CLK_NS 8
`define RCAL_INSTR_NS 32
`define RCAL_UNLOCK_CYC ((`RCAL_INSTR_NS) / (`RCAL_CLK_NS))
`define RCAL_SYNC_WIN 14'd32
`endif

// ### rtl/rcal_pkg.sv
package rcal_pkg;
  typedef enum logic [1:0] {
    RCAL_KEY_IDLE,
    RCAL_KEY_HALF,
    RCAL_KEY_OPEN
  } rcal_key_t;
  typedef logic [7:0] rcal_byte_t;
endpackage

// ### rtl/rcal_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcal_params.svh"

// How it works
// - Safety flag low only while time registers cannot roll over.
// - Time register writes accepted only while unlock bit 5 is set.
// - Unlock set only right after key writes 0x55 then 0xAA.
// - Timer pointer picks min/sec, wday/hour, month/day, none/year.
// - Timer high window access decrements pointer, holding at 00.
// - Alarm pointer picks min/sec, wday/hour, month/day, nothing.
// - Alarm high window access decrements pointer, holding at 00.
// - Each hour four times signed trim adds or removes pulses.
// - Alarm enable self-clears on alarm unless endless or count nonzero.
// - Interval mask picks matching digits, half second up to year.
// - Yearly alarm compares time, day and month, not the year; there is no leap-year check.
// - Each alarm decrements repeat count; at 00 final alarm then off.
// - Count FF gives up to 255 repeats.
// - Endless mode wraps count from 00 to FF, alarm stays on.
// - Count 00 without endless gives exactly one alarm.
// - Every alarm event raises an interrupt request.
// - Alarm pulse toggles per alarm, half alarm rate square wave.
// - Pin select 00 routes alarm pulse, 01 the seconds clock.
// - Timer window and timer enable writes ignored while unlock is clear; alarm window writes always land.
// - Writing the minutes/seconds pair clears the prescalers.
// - Device reset clears repeat count and alarm, timer keeps running.
module rcal_top (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillator and device reset
  input wire logic osc_in,
  input wire logic dev_reset,
  // Outputs
  output logic clk_pin_out,
  output logic clk_pin_oe,
  output logic alarm_irq,
  output logic day_carry
);
  // Fields
  logic timer_en, unlock, pin_oe;
  logic [1:0] tptr, aptr, pin_sel;
  logic [7:0] trim;
  logic alrm_en, endless;
  logic [3:0] alarm_interval_mask;
  logic [7:0] rpt;
  logic [7:0] t_sec, t_min, t_hr, t_wday, t_day, t_mon, t_year;
  logic [7:0] a_sec, a_min, a_hr, a_wday, a_day, a_mon;
  rcal_pkg::rcal_key_t key_st;
  logic [2:0] key_cnt;
  logic [13:0] hs_cnt;
  logic [9:0] skip_cnt;
  logic halfsec, alarm_pulse, eval_pend;
  logic osc_s1, osc_s2, osc_s3;

  // Bus decode
  wire setup = psel && !penable;
  wire acc = psel && penable && ce;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire [7:0] wd = pwdata[7:0];
  wire hit_cfg = paddr == `RCAL_OFS_CFG;
  wire hit_trim = paddr == `RCAL_OFS_TRIM;
  wire hit_pad = paddr == `RCAL_OFS_PAD;
  wire hit_acfg = paddr == `RCAL_OFS_ACFG;
  wire hit_rpt = paddr == `RCAL_OFS_RPT;
  wire hit_tvh = paddr == `RCAL_OFS_TVH;
  wire hit_tvl = paddr == `RCAL_OFS_TVL;
  wire hit_avh = paddr == `RCAL_OFS_AVH;
  wire hit_avl = paddr == `RCAL_OFS_AVL;
  wire hit_key = paddr == `RCAL_OFS_KEY;
  wire mapped = hit_cfg | hit_trim | hit_pad | hit_acfg | hit_rpt | hit_tvh | hit_tvl
    | hit_avh | hit_avl | hit_key;
  wire wr_tvh = wr && hit_tvh && unlock;
  wire wr_tvl = wr && hit_tvl && unlock;
  wire wr_avh = wr && hit_avh;
  wire wr_avl = wr && hit_avl;
  wire key_open = key_st == rcal_pkg::RCAL_KEY_OPEN;
  wire minutes_seconds_pair_wr = (wr_tvh || wr_tvl) && tptr == 2'b00;

  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  // Oscillator tick, two flops before any logic
  wire osc_tick = osc_s2 && !osc_s3;
  wire stalled = skip_cnt != 10'd0;
  wire hs_wrap = timer_en && osc_tick && !stalled && hs_cnt == 14'h3FFF;
  wire sec_inc = hs_wrap && halfsec;
  wire sec_roll = sec_inc && t_sec == 8'h59;
  wire min_roll = sec_roll && t_min == 8'h59;
  wire hr_roll = min_roll && t_hr == 8'h23;
  // Flag rises late in the second half, drops once the count is past
  wire sync_flag = timer_en && halfsec && hs_cnt >= 14'h3FFF - `RCAL_SYNC_WIN;
  wire signed [10:0] trim_x4 = {{1{trim[7]}}, trim, 2'b00};

  function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] top);
    logic [7:0] r;
    r = 8'h00;
    if (v == top) begin
      r = 8'h00;
    end else if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  // Window read selection
  wire [7:0] tvh_rd = tptr == 2'b00 ? t_min : tptr == 2'b01 ? t_wday :
    tptr == 2'b10 ? t_mon : 8'h00;
  wire [7:0] tvl_rd = tptr == 2'b00 ? t_sec : tptr == 2'b01 ? t_hr :
    tptr == 2'b10 ? t_day : t_year;
  wire [7:0] avh_rd = aptr == 2'b00 ? a_min : aptr == 2'b01 ? a_wday :
    aptr == 2'b10 ? a_mon : 8'h00;
  wire [7:0] avl_rd = aptr == 2'b00 ? a_sec : aptr == 2'b01 ? a_hr :
    aptr == 2'b10 ? a_day : 8'h00;
  wire [7:0] cfg_rd = {timer_en, 1'b0, unlock, sync_flag, halfsec, pin_oe, tptr};
  wire [7:0] rd_mux = hit_cfg ? cfg_rd : hit_trim ? trim :
    hit_pad ? {5'd0, pin_sel, 1'b0} : hit_acfg ? {alrm_en, endless, alarm_interval_mask, aptr} :
    hit_rpt ? rpt : hit_tvh ? tvh_rd : hit_tvl ? tvl_rd :
    hit_avh ? avh_rd : hit_avl ? avl_rd : 8'h00;

  // Alarm match
  wire m_s1 = a_sec[3:0] == t_sec[3:0];
  wire m_s = a_sec == t_sec;
  wire m_m1 = a_min[3:0] == t_min[3:0];
  wire m_ms = m_s && a_min == t_min;
  wire m_h = m_ms && a_hr == t_hr;
  logic match;
  always_comb begin
    case (alarm_interval_mask)
      4'd0: match = 1'b1;
      4'd1: match = !halfsec;
      4'd2: match = !halfsec && m_s1;
      4'd3: match = !halfsec && m_s;
      4'd4: match = !halfsec && m_s && m_m1;
      4'd5: match = !halfsec && m_ms;
      4'd6: match = !halfsec && m_h;
      4'd7: match = !halfsec && m_h && a_wday == t_wday;
      4'd8: match = !halfsec && m_h && a_day == t_day;
      // Feb 29 matches only when the calendar reaches it
      4'd9: match = !halfsec && m_h && a_day == t_day && a_mon == t_mon;
      default: match = 1'b0;
    endcase
  end
  wire alarm_evt = ce && eval_pend && alrm_en && match;

  // Next repeat state
  logic [7:0] next_rpt;
  logic next_alrm_en;
  always_comb begin
    next_rpt = rpt;
    next_alrm_en = alrm_en;
    if (rpt != 8'h00) begin
      next_rpt = rpt - 8'h01;
    end else if (endless) begin
      next_rpt = `RCAL_RPT_WRAP;
    end else begin
      next_alrm_en = 1'b0;
    end
  end

  // Input synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end else if (ce) begin
      osc_s1 <= osc_in;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end

  // Unlock key sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_st <= rcal_pkg::RCAL_KEY_IDLE;
      key_cnt <= 3'd0;
    end else if (ce) begin
      case (key_st)
        rcal_pkg::RCAL_KEY_IDLE: begin
          if (wr && hit_key && wd == `RCAL_KEY_FIRST) begin
            key_st <= rcal_pkg::RCAL_KEY_HALF;
          end
        end
        rcal_pkg::RCAL_KEY_HALF: begin
          if (wr && hit_key && wd == `RCAL_KEY_SECOND) begin
            key_st <= rcal_pkg::RCAL_KEY_OPEN;
            key_cnt <= 3'(`RCAL_UNLOCK_CYC);
          end else if (wr) begin
            key_st <= rcal_pkg::RCAL_KEY_IDLE;
          end
        end
        rcal_pkg::RCAL_KEY_OPEN: begin
          key_cnt <= key_cnt - 3'd1;
          if (wr || key_cnt == 3'd1) begin
            key_st <= rcal_pkg::RCAL_KEY_IDLE;
          end
        end
        default: key_st <= rcal_pkg::RCAL_KEY_IDLE;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_en <= 1'b0;
      unlock <= 1'b0;
      pin_oe <= 1'b0;
      tptr <= 2'b00;
      trim <= 8'h00;
      pin_sel <= 2'b00;
      aptr <= 2'b00;
      alarm_interval_mask <= 4'd0;
      endless <= 1'b0;
    end else if (ce) begin
      if (wr && hit_cfg) begin
        // Clearing is always allowed; setting needs the open key window
        unlock <= wd[`RCAL_CFG_UNLOCK] && (unlock || key_open);
        if (unlock) begin
          timer_en <= wd[`RCAL_CFG_EN];
        end
        pin_oe <= wd[`RCAL_CFG_OE];
        tptr <= wd[1:0];
      end else if ((rd || wr) && hit_tvh && tptr != 2'b00) begin
        tptr <= tptr - 2'b01;
      end
      if (wr && hit_trim) begin
        trim <= wd;
      end
      if (wr && hit_pad) begin
        pin_sel <= wd[2:1];
      end
      if (wr && hit_acfg) begin
        alarm_interval_mask <= wd[5:2];
        endless <= wd[`RCAL_ACFG_ENDLESS];
        aptr <= wd[1:0];
      end else if ((rd || wr) && hit_avh && aptr != 2'b00) begin
        aptr <= aptr - 2'b01;
      end
    end
  end

  // Alarm enable and repeat count, cleared by either reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alrm_en <= 1'b0;
      rpt <= `RCAL_RPT_RESET;
    end else if (ce) begin
      if (dev_reset) begin
        alrm_en <= 1'b0;
        rpt <= `RCAL_RPT_RESET;
      end else if (alarm_evt) begin
        alrm_en <= next_alrm_en;
        rpt <= next_rpt;
      end else begin
        if (wr && hit_acfg) begin
          alrm_en <= wd[`RCAL_ACFG_EN];
        end
        if (wr && hit_rpt) begin
          rpt <= wd;
        end
      end
    end
  end

  // Prescaler with hourly trim; only the enable and minutes_seconds_pair write touch it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_cnt <= 14'd0;
      halfsec <= 1'b0;
      skip_cnt <= 10'd0;
    end else if (ce) begin
      if (minutes_seconds_pair_wr) begin
        hs_cnt <= 14'd0;
        halfsec <= 1'b0;
        skip_cnt <= 10'd0;
      end else if (min_roll && !trim_x4[10]) begin
        hs_cnt <= {3'd0, trim_x4};
        halfsec <= 1'b0;
      end else if (min_roll) begin
        hs_cnt <= 14'd0;
        halfsec <= 1'b0;
        skip_cnt <= 10'(-trim_x4);
      end else if (timer_en && osc_tick) begin
        if (stalled) begin
          skip_cnt <= skip_cnt - 10'd1;
        end else begin
          hs_cnt <= hs_cnt + 14'd1;
          if (hs_wrap) begin
            halfsec <= !halfsec;
          end
        end
      end
    end
  end

  // Time values; a software write wins over the count for its own field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_sec <= 8'h00;
      t_min <= 8'h00;
      t_hr <= 8'h00;
      t_wday <= 8'h00;
      t_day <= 8'h01;
      t_mon <= 8'h01;
      t_year <= 8'h00;
    end else if (ce) begin
      if (wr_tvl && tptr == 2'b00) begin
        t_sec <= wd;
      end else if (sec_inc) begin
        t_sec <= bcd_inc(t_sec, 8'h59);
      end
      if (wr_tvh && tptr == 2'b00) begin
        t_min <= wd;
      end else if (sec_roll) begin
        t_min <= bcd_inc(t_min, 8'h59);
      end
      if (wr_tvl && tptr == 2'b01) begin
        t_hr <= wd;
      end else if (min_roll) begin
        t_hr <= bcd_inc(t_hr, 8'h23);
      end
      if (wr_tvh && tptr == 2'b01) begin
        t_wday <= wd;
      end else if (hr_roll) begin
        t_wday <= t_wday == 8'h06 ? 8'h00 : t_wday + 8'h01;
      end
      if (wr_tvl && tptr == 2'b10) begin
        t_day <= wd;
      end
      if (wr_tvh && tptr == 2'b10) begin
        t_mon <= wd;
      end
      if (wr_tvl && tptr == 2'b11) begin
        t_year <= wd;
      end
    end
  end

  // Alarm values through the alarm window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_sec <= 8'h00;
      a_min <= 8'h00;
      a_hr <= 8'h00;
      a_wday <= 8'h00;
      a_day <= 8'h01;
      a_mon <= 8'h01;
    end else if (ce) begin
      if (wr_avl && aptr == 2'b00) a_sec <= wd;
      if (wr_avh && aptr == 2'b00) a_min <= wd;
      if (wr_avl && aptr == 2'b01) a_hr <= wd;
      if (wr_avh && aptr == 2'b01) a_wday <= wd;
      if (wr_avl && aptr == 2'b10) a_day <= wd;
      if (wr_avh && aptr == 2'b10) a_mon <= wd;
    end
  end

  // Outputs; match evaluated one cycle after the half-second count settles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eval_pend <= 1'b0;
      alarm_pulse <= 1'b0;
      alarm_irq <= 1'b0;
      day_carry <= 1'b0;
      clk_pin_out <= 1'b0;
      clk_pin_oe <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      eval_pend <= hs_wrap;
      alarm_irq <= alarm_evt;
      day_carry <= hr_roll;
      if (alarm_evt) begin
        alarm_pulse <= !alarm_pulse;
      end
      case (pin_sel)
        `RCAL_SEL_ALARM: clk_pin_out <= alarm_pulse;
        `RCAL_SEL_SECONDS: clk_pin_out <= halfsec;
        default: clk_pin_out <= 1'b0;
      endcase
      clk_pin_oe <= pin_oe;
      if (setup) begin
        prdata <= {24'h00_0000, rd_mux};
      end
    end
  end

  property p_lock;
    @(posedge pclk) disable iff (!presetn)
    (wr && (hit_tvh || hit_tvl) && !unlock && !timer_en) |=>
      {t_year, t_mon, t_day, t_wday, t_hr, t_min, t_sec} ==
      $past({t_year, t_mon, t_day, t_wday, t_hr, t_min, t_sec});
  endproperty
  a_lock: assert property (p_lock) else $error("locked window write took effect");
  property p_key;
    @(posedge pclk) disable iff (!presetn)
    $rose(unlock) |-> $past(key_open);
  endproperty
  a_key: assert property (p_key) else $error("unlock set outside key window");
  property p_tptr;
    @(posedge pclk) disable iff (!presetn)
    (acc && hit_tvh && tptr != 2'b00) |=> tptr == $past(tptr) - 2'b01;
  endproperty
  a_tptr: assert property (p_tptr) else $error("timer pointer not decremented");
  property p_aptr;
    @(posedge pclk) disable iff (!presetn)
    (acc && hit_avh && aptr == 2'b00) |=> aptr == 2'b00;
  endproperty
  a_aptr: assert property (p_aptr) else $error("alarm pointer left 00");
  property p_sync;
    @(posedge pclk) disable iff (!presetn)
    sec_inc |-> sync_flag ##1 !sync_flag;
  endproperty
  a_sync: assert property (p_sync) else $error("safety flag not around increment");
  property p_once;
    @(posedge pclk) disable iff (!presetn)
    (alarm_evt && rpt == 8'h00 && !endless && !dev_reset) |=> !alrm_en;
  endproperty
  a_once: assert property (p_once) else $error("alarm enable not cleared");
  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
    (alarm_evt && rpt == 8'h00 && endless && !dev_reset) |=> rpt == 8'hFF && alrm_en;
  endproperty
  a_wrap: assert property (p_wrap) else $error("endless count did not wrap");
  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    alarm_evt |=> alarm_irq && alarm_pulse != $past(alarm_pulse);
  endproperty
  a_irq: assert property (p_irq) else $error("alarm without irq or toggle");
  property p_pin;
    @(posedge pclk) disable iff (!presetn)
    (ce && pin_sel == 2'b00) |=> clk_pin_out == $past(alarm_pulse);
  endproperty
  a_pin: assert property (p_pin) else $error("pin not carrying alarm pulse");
  property p_secpin;
    @(posedge pclk) disable iff (!presetn)
    (ce && pin_sel == 2'b01) |=> clk_pin_out == $past(halfsec);
  endproperty
  a_secpin: assert property (p_secpin) else $error("pin not carrying seconds clock");
endmodule
`default_nettype wire

// ### test/tb_rcal_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcal_params.svh"
module tb_rcal_top;
  // Bus and device inputs
  logic pclk;
  logic presetn;
  logic ce;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic osc_in;
  logic dev_reset;
  // Observed outputs
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic clk_pin_out;
  logic clk_pin_oe;
  logic alarm_irq;
  logic day_carry;
  // Bench state
  int miscompares;
  int total_checks;
  logic [7:0] rd;
  logic err;
  logic pin0;
  logic carry_seen = 1'b0;
  // Window contents by pointer, timer then alarm; alarm slot 3 is never used
  logic [7:0] lo_v [2][4] = '{'{8'h42, 8'h13, 8'h15, 8'h25}, '{8'h11, 8'h08, 8'h21, 8'h00}};
  logic [7:0] hi_v [2][4] = '{'{8'h30, 8'h03, 8'h07, 8'h00}, '{8'h05, 8'h02, 8'h11, 8'h00}};

  rcal_top DUT (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .osc_in(osc_in),
    .dev_reset(dev_reset),
    .clk_pin_out(clk_pin_out),
    .clk_pin_oe(clk_pin_oe),
    .alarm_irq(alarm_irq),
    .day_carry(day_carry)
  );

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Fastest oscillator the two-flop synchroniser still resolves
  always @(posedge pclk) begin
    osc_in <= ~osc_in;
  end

  // Day carry is a one-cycle pulse, so latch it
  always @(posedge pclk) begin
    if (day_carry === 1'b1) begin
      carry_seen <= 1'b1;
    end
  end

  task automatic print_verdict();
    $display("Checks %0d, miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr_en, input logic [7:0] addr, input logic [7:0] data);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= addr;
    pwdata <= {24'h00_0000, data};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n == 100) begin
      miscompares++;
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp,
                      input logic [7:0] msk = 8'hFF);
    apb(1'b0, a, 8'h00);
    check(what, rd & msk, exp);
  endtask

  task automatic unlock(input logic [7:0] cfg);
    wr(`RCAL_OFS_KEY, `RCAL_KEY_FIRST);
    wr(`RCAL_OFS_KEY, `RCAL_KEY_SECOND);
    wr(`RCAL_OFS_CFG, cfg);
  endtask

  // Low then high at each pointer; the high access moves the pointer down
  task automatic walk(input int alm, input bit do_wr, input int top);
    logic [7:0] hi_a;
    logic [7:0] lo_a;
    hi_a = (alm == 1) ? `RCAL_OFS_AVH : `RCAL_OFS_TVH;
    lo_a = (alm == 1) ? `RCAL_OFS_AVL : `RCAL_OFS_TVL;
    for (int p = top; p >= 0; p--) begin
      if (do_wr) begin
        wr(lo_a, lo_v[alm][p]);
        wr(hi_a, hi_v[alm][p]);
      end else begin
        rchk("window low", lo_a, lo_v[alm][p]);
        rchk("window high", hi_a, hi_v[alm][p]);
      end
    end
  endtask

  task automatic wait_irq(input string what);
    int n;
    n = 0;
    while (alarm_irq !== 1'b1 && n < 40000) begin
      @(posedge pclk);
      n++;
    end
    check(what, {7'h00, alarm_irq}, 8'h01);
    repeat (3) @(posedge pclk);
  endtask

  initial begin
    repeat (90000) @(posedge pclk);
    miscompares++;
    print_verdict();
  end

  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    osc_in = 1'b0;
    dev_reset = 1'b0;
    miscompares = 0;
    total_checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 5; a++) begin
      rchk("reset value", 8'(a * 4), 8'h00);
    end
    apb(1'b0, 8'h28, 8'h00);
    check("unmapped error", {7'h00, err}, 8'h01);
    check("unmapped data", rd, 8'h00);
    // Locked: enable bit and year window must not change
    wr(`RCAL_OFS_CFG, 8'h83);
    wr(`RCAL_OFS_TVL, 8'h99);
    rchk("locked enable", `RCAL_OFS_CFG, 8'h03, 8'hE7);
    rchk("locked year", `RCAL_OFS_TVL, 8'h00);
    // A write between key and set cancels the unlock
    wr(`RCAL_OFS_KEY, `RCAL_KEY_FIRST);
    wr(`RCAL_OFS_KEY, `RCAL_KEY_SECOND);
    wr(`RCAL_OFS_TRIM, 8'h00);
    wr(`RCAL_OFS_CFG, 8'h23);
    rchk("late unlock", `RCAL_OFS_CFG, 8'h03, 8'hE7);
    unlock(8'h23);
    rchk("unlock", `RCAL_OFS_CFG, 8'h23, 8'hE7);
    walk(0, 1'b1, 3);
    rchk("timer pointer end", `RCAL_OFS_CFG, 8'h20, 8'hE7);
    wr(`RCAL_OFS_ACFG, 8'h02);
    walk(1, 1'b1, 2);
    rchk("alarm pointer end", `RCAL_OFS_ACFG, 8'h00);
    for (int m = 0; m < 10; m++) begin
      wr(`RCAL_OFS_ACFG, 8'(m << 2));
      rchk("interval mask", `RCAL_OFS_ACFG, 8'(m << 2));
    end
    wr(`RCAL_OFS_TRIM, 8'hFC);
    rchk("drift trim", `RCAL_OFS_TRIM, 8'hFC);
    wr(`RCAL_OFS_CFG, 8'h03);
    walk(0, 1'b0, 3);
    rchk("timer pointer hold", `RCAL_OFS_TVH, 8'h30);
    rchk("timer pointer zero", `RCAL_OFS_CFG, 8'h00, 8'hE7);
    wr(`RCAL_OFS_ACFG, 8'h02);
    walk(1, 1'b0, 2);
    // Endless alarm every half second, pin on alarm pulse
    wr(`RCAL_OFS_RPT, 8'h00);
    // Clock at 23:59:59 so the second increment carries into the day
    unlock(8'h21);
    wr(`RCAL_OFS_TVL, 8'h23);
    wr(`RCAL_OFS_TVH, 8'h03);
    wr(`RCAL_OFS_TVL, 8'h59);
    wr(`RCAL_OFS_TVH, 8'h59);
    wr(`RCAL_OFS_ACFG, 8'hC0);
    // Enable only lands once unlock is already set
    wr(`RCAL_OFS_CFG, 8'hA4);
    repeat (2) @(posedge pclk);
    pin0 = clk_pin_out;
    check("pin enable", {7'h00, clk_pin_oe}, 8'h01);
    wait_irq("first alarm");
    check("pulse after first", {7'h00, clk_pin_out}, {7'h00, ~pin0});
    rchk("repeat wrap", `RCAL_OFS_RPT, `RCAL_RPT_WRAP);
    rchk("endless keeps enable", `RCAL_OFS_ACFG, 8'hC0);
    rchk("flag clear after edge", `RCAL_OFS_CFG, 8'hA4, 8'hF7);
    check("no carry yet", {7'h00, carry_seen}, 8'h00);
    rchk("seconds read one", `RCAL_OFS_TVL, 8'h59);
    rchk("seconds read two", `RCAL_OFS_TVL, 8'h59);
    @(posedge pclk);
    dev_reset <= 1'b1;
    @(posedge pclk);
    dev_reset <= 1'b0;
    rchk("device reset count", `RCAL_OFS_RPT, `RCAL_RPT_RESET);
    rchk("device reset alarm", `RCAL_OFS_ACFG, 8'h40);
    rchk("timer survives", `RCAL_OFS_CFG, 8'h80, 8'h80);
    // Alarm pulse and half second are both high here
    wr(`RCAL_OFS_PAD, 8'h04);
    repeat (2) @(posedge pclk);
    check("pin select off", {7'h00, clk_pin_out}, 8'h00);
    wr(`RCAL_OFS_PAD, 8'h02);
    repeat (2) @(posedge pclk);
    check("seconds clock high", {7'h00, clk_pin_out}, 8'h01);
    // Single shot: count zero, no endless
    wr(`RCAL_OFS_ACFG, 8'h80);
    wait_irq("last alarm");
    wr(`RCAL_OFS_PAD, 8'h00);
    repeat (2) @(posedge pclk);
    check("pulse after last", {7'h00, clk_pin_out}, {7'h00, pin0});
    check("day carry", {7'h00, carry_seen}, 8'h01);
    rchk("seconds after carry", `RCAL_OFS_TVL, 8'h00);
    rchk("minutes after carry", `RCAL_OFS_TVH, 8'h00);
    rchk("enable self clear", `RCAL_OFS_ACFG, 8'h00);
    rchk("count stays zero", `RCAL_OFS_RPT, 8'h00);
    wr(`RCAL_OFS_PAD, 8'h02);
    rchk("pin select", `RCAL_OFS_PAD, 8'h02);
    apb(1'b0, `RCAL_OFS_CFG, 8'h00);
    check("seconds clock on pin", {7'h00, clk_pin_out}, {7'h00, rd[3]});
    print_verdict();
  end
endmodule
`default_nettype wire
